// ===== hdl/pos_scheduler.sv
/*
  Programmable output scheduler: entry table, event scan, 20 relay outputs.
  Assumes an APB master on REF_CLK and software that mirrors the machine
  formula, step and event levels into the MACH register and step time into STEPTIME.
*/
// Chosen here: register access over APB and the register addresses.
// Notes on behaviour
// - Twenty independent relay outputs, each driven by the programmed schedule.
// - Table of 4096 entries; at most twenty entries fire per step; the core only caps twenty active at once.
// - Entry formula 1..999 and step 1..50 select when it applies.
// - Formulas above 99 never trigger unless the machine is networked.
// - Entry output index 0..19, below the configured output count.
// - Several entries may drive one output, each independently.
// - Event code zero disables the entry.
// - Code one fires at bath step start.
// - First step counts as started at the operator start command.
// - Code two fires at drain sequence start.
// - Code three fires at extract step start.
// - Output turns on after 0..9999 second delay; zero delay is immediate.
// - Delay longer than step time means the entry never actuates.
// - Output stays on for its duration; zero duration never operates.
// - Output drops when its controlling event ends.
`timescale 1ns/1ps
module pos_scheduler
#(
  parameter int TICK_CYCLES = pos_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Relays
  output logic [pos_pkg::N_OUT-1:0] OUT_RELAY
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [pos_pkg::TBL_AW-1:0] IDX_LAST = pos_pkg::TBL_AW'(pos_pkg::TBL_DEPTH - 1);

  // Lowest set bit of a small mask, as an index
  function automatic logic [4:0] first_set(input logic [pos_pkg::N_OUT-1:0] m);
    logic [4:0] r;
    r = '0;
    for (int i = pos_pkg::N_OUT - 1; i >= 0; i--)
      if (m[i])
        r = 5'(i);
    return r;
  endfunction

  // Table storage
  pos_pkg::pos_entry_t tbl [pos_pkg::TBL_DEPTH];

  // Registers
  logic net_q;
  logic [pos_pkg::OUT_W-1:0] nout_q;
  logic [pos_pkg::FORM_W-1:0] form_q;
  logic [pos_pkg::STEP_W-1:0] step_q;
  logic [pos_pkg::NEVT-1:0] lvl_q;
  logic [pos_pkg::NEVT-1:0] lvl_prev_q;
  logic [pos_pkg::TIME_W-1:0] step_time_q;
  logic [pos_pkg::TBL_AW-1:0] tbl_addr_q;
  logic [31:0] w0_q;
  pos_pkg::pos_entry_t sw_rd_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [pos_pkg::N_OUT-1:0] relay_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [pos_pkg::NEVT-1:0] pend_q;
  pos_pkg::pos_scan_t state_q;
  logic [pos_pkg::TBL_AW-1:0] idx_q;
  logic [pos_pkg::EVT_W-1:0] cur_evt_q;
  pos_pkg::pos_entry_t rd_q;
  logic rd_vld_q;

  // APB decode
  wire acc = PSEL & PENABLE & ~pready_q;
  wire wr = acc & PWRITE;
  wire hit_ctrl = (PADDR == pos_pkg::A_CTRL);
  wire hit_mach = (PADDR == pos_pkg::A_MACH);
  wire hit_st = (PADDR == pos_pkg::A_STEPTIME);
  wire hit_ta = (PADDR == pos_pkg::A_TBL_ADDR);
  wire hit_w0 = (PADDR == pos_pkg::A_TBL_W0);
  wire hit_w1 = (PADDR == pos_pkg::A_TBL_W1);
  wire hit_stat = (PADDR == pos_pkg::A_STATUS);
  wire mapped = hit_ctrl | hit_mach | hit_st | hit_ta | hit_w0 | hit_w1 | hit_stat;
  wire busy = (state_q != pos_pkg::SC_IDLE);

  wire [31:0] rd_ctrl = {19'h0, nout_q, 7'h0, net_q};
  wire [31:0] rd_mach = {5'h0, lvl_q, 2'h0, step_q, 6'h0, form_q};
  wire [31:0] rd_st = {18'h0, step_time_q};
  wire [31:0] rd_ta = {20'h0, tbl_addr_q};
  wire [31:0] rd_w0 = {sw_rd_q.evt, 1'b0, sw_rd_q.outn, 2'h0, sw_rd_q.step, 6'h0, sw_rd_q.form};
  wire [31:0] rd_w1 = {2'h0, sw_rd_q.dur, 2'h0, sw_rd_q.dly};
  wire [31:0] rd_stat = {7'h0, busy, 4'h0, relay_q};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_mach ? rd_mach : hit_st ? rd_st :
                       hit_ta ? rd_ta : hit_w0 ? rd_w0 : hit_w1 ? rd_w1 :
                       hit_stat ? rd_stat : 32'h0000_0000;

  // Staged entry from W0 plus the W1 write data
  wire pos_pkg::pos_entry_t wr_ent = '{
    form: w0_q[pos_pkg::FORM_W-1:0],
    step: w0_q[pos_pkg::W0_STEP_LSB +: pos_pkg::STEP_W],
    outn: w0_q[pos_pkg::W0_OUT_LSB +: pos_pkg::OUT_W],
    evt: w0_q[pos_pkg::W0_EVT_LSB +: pos_pkg::EVT_W],
    dly: PWDATA[pos_pkg::TIME_W-1:0],
    dur: PWDATA[pos_pkg::W1_DUR_LSB +: pos_pkg::TIME_W]
  };

  // Event edges; a new event start is queued until scanned
  wire [pos_pkg::NEVT-1:0] rise = lvl_q & ~lvl_prev_q;
  wire [pos_pkg::NEVT-1:0] fall = ~lvl_q & lvl_prev_q;
  wire start_scan = (state_q == pos_pkg::SC_IDLE) & (|pend_q);
  wire [pos_pkg::EVT_W-1:0] pick_evt = pend_q[0] ? pos_pkg::EVT_BATH :
                                       pend_q[1] ? pos_pkg::EVT_DRAIN : pos_pkg::EVT_EXTRACT;
  wire [pos_pkg::NEVT-1:0] taken = start_scan ? (pend_q & ~(pend_q - 3'h1)) : 3'h0;

  // Entry qualification
  wire [pos_pkg::NEVT:0] lvl_x = {lvl_q, 1'b0};
  wire form_ok = (rd_q.form >= pos_pkg::FORM_MIN) && (rd_q.form <= pos_pkg::FORM_MAX) &&
                 (net_q || rd_q.form <= pos_pkg::FORM_LOCAL_MAX);
  wire step_ok = (rd_q.step >= pos_pkg::STEP_MIN) && (rd_q.step <= pos_pkg::STEP_MAX);
  wire out_ok = (rd_q.outn <= pos_pkg::OUT_MAX) && (rd_q.outn < nout_q);
  wire match = (rd_q.form == form_q) && (rd_q.step == step_q) && (rd_q.evt == cur_evt_q);
  wire evt_ok = (rd_q.evt != pos_pkg::EVT_OFF) && lvl_x[rd_q.evt];
  wire time_ok = (rd_q.dur != '0) && (rd_q.dly <= step_time_q) &&
                 (rd_q.dly <= pos_pkg::TIME_MAX) && (rd_q.dur <= pos_pkg::TIME_MAX);
  wire [pos_pkg::N_OUT-1:0] busy_vec;
  wire [pos_pkg::N_OUT-1:0] free_vec = ~busy_vec;
  wire hit = rd_vld_q & match & form_ok & step_ok & out_ok & evt_ok & time_ok & (|free_vec);
  wire [4:0] free_idx = first_set(free_vec);

  // Slots, one per concurrently active entry
  pos_slot_if sl [pos_pkg::N_OUT] ();
  logic [pos_pkg::N_OUT-1:0] on_mask [pos_pkg::N_OUT];
  logic [pos_pkg::N_OUT-1:0] relay_d;

  for (genvar g = 0; g < pos_pkg::N_OUT; g++)
  begin : g_slot
    assign sl[g].load = hit && (free_idx == 5'(g));
    assign sl[g].tick = tick_q;
    assign sl[g].end_mask = fall;
    assign sl[g].evt = rd_q.evt;
    assign sl[g].dly = rd_q.dly;
    assign sl[g].dur = rd_q.dur;
    assign sl[g].outn = rd_q.outn;
    assign busy_vec[g] = sl[g].busy;
    assign on_mask[g] = sl[g].on ? (pos_pkg::N_OUT'(1) << sl[g].on_out) : '0;
    pos_slot u_slot
    (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .bus(sl[g])
    );
  end

  // Any slot may drive any output
  always_comb
  begin
    relay_d = '0;
    for (int i = 0; i < pos_pkg::N_OUT; i++)
      relay_d = relay_d | on_mask[i];
  end

  // Seconds tick from the system clock
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      net_q <= 1'b0;
      nout_q <= pos_pkg::NOUT_RST;
      form_q <= '0;
      step_q <= '0;
      lvl_q <= '0;
      step_time_q <= '0;
      tbl_addr_q <= '0;
      w0_q <= '0;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        net_q <= PWDATA[pos_pkg::CTRL_NET_BIT];
        nout_q <= PWDATA[pos_pkg::CTRL_NOUT_LSB +: pos_pkg::OUT_W];
      end
      if (hit_mach)
      begin
        form_q <= PWDATA[pos_pkg::FORM_W-1:0];
        step_q <= PWDATA[pos_pkg::MACH_STEP_LSB +: pos_pkg::STEP_W];
        lvl_q <= PWDATA[pos_pkg::MACH_EVT_LSB +: pos_pkg::NEVT];
      end
      if (hit_st)
        step_time_q <= PWDATA[pos_pkg::TIME_W-1:0];
      if (hit_ta)
        tbl_addr_q <= PWDATA[pos_pkg::TBL_AW-1:0];
      if (hit_w0)
        w0_q <= PWDATA;
    end
  end

  // Table write port; software read port follows the table address
  always_ff @(posedge REF_CLK)
  begin
    if (wr && hit_w1)
      tbl[tbl_addr_q] <= wr_ent;
    sw_rd_q <= tbl[tbl_addr_q];
    rd_q <= tbl[idx_q];
  end

  // APB answer, one wait state
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q <= (acc && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // Event queue: a start wins over its own retirement
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lvl_prev_q <= '0;
      pend_q <= '0;
    end
    else
    begin
      lvl_prev_q <= lvl_q;
      pend_q <= ((pend_q & ~taken) | rise) & lvl_q;
    end
  end

  // Table scan on each event start; the full sweep takes about 33 us
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= pos_pkg::SC_IDLE;
      idx_q <= '0;
      cur_evt_q <= pos_pkg::EVT_OFF;
      rd_vld_q <= 1'b0;
    end
    else
    begin
      rd_vld_q <= (state_q == pos_pkg::SC_RUN);
      case (state_q)
        pos_pkg::SC_IDLE:
        begin
          idx_q <= '0;
          if (start_scan)
          begin
            cur_evt_q <= pick_evt;
            state_q <= pos_pkg::SC_RUN;
          end
        end
        pos_pkg::SC_RUN:
        begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == IDX_LAST)
            state_q <= pos_pkg::SC_LAST;
        end
        pos_pkg::SC_LAST:
          state_q <= pos_pkg::SC_IDLE;
        default:
          state_q <= pos_pkg::SC_IDLE;
      endcase
    end
  end

  // Relay outputs; all off in reset
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      relay_q <= '0;
    else
      relay_q <= relay_d;
  end

  assign OUT_RELAY = relay_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

endmodule

// ===== inc/pos_pkg.sv
/*
  Constants, field layouts and types of the programmable output scheduler.
  Assumes a 125 MHz system clock and a 32-bit APB register port.
*/
package pos_pkg;

  // Sizes
  localparam int N_OUT = 20;
  localparam int TBL_DEPTH = 4096;
  localparam int TBL_AW = 12;
  localparam int FORM_W = 10;
  localparam int STEP_W = 6;
  localparam int OUT_W = 5;
  localparam int EVT_W = 2;
  localparam int TIME_W = 14;
  localparam int NEVT = 3;

  // Value ranges
  localparam logic [FORM_W-1:0] FORM_MIN = 10'h001;
  localparam logic [FORM_W-1:0] FORM_MAX = 10'h3E7;
  localparam logic [FORM_W-1:0] FORM_LOCAL_MAX = 10'h063;
  localparam logic [STEP_W-1:0] STEP_MIN = 6'h01;
  localparam logic [STEP_W-1:0] STEP_MAX = 6'h32;
  localparam logic [OUT_W-1:0] OUT_MAX = 5'h13;
  localparam logic [TIME_W-1:0] TIME_MAX = 14'h270F;

  // Event codes
  localparam logic [EVT_W-1:0] EVT_OFF = 2'h0;
  localparam logic [EVT_W-1:0] EVT_BATH = 2'h1;
  localparam logic [EVT_W-1:0] EVT_DRAIN = 2'h2;
  localparam logic [EVT_W-1:0] EVT_EXTRACT = 2'h3;

  // Seconds tick
  localparam longint CLK_HZ = 125_000_000;
  localparam longint TICK_S = 1;
  localparam int TICK_CYCLES = int'(CLK_HZ * TICK_S);

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MACH = 8'h04;
  localparam logic [7:0] A_STEPTIME = 8'h08;
  localparam logic [7:0] A_TBL_ADDR = 8'h0C;
  localparam logic [7:0] A_TBL_W0 = 8'h10;
  localparam logic [7:0] A_TBL_W1 = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_NET_BIT = 0;
  localparam int CTRL_NOUT_LSB = 8;
  localparam int MACH_STEP_LSB = 16;
  localparam int MACH_EVT_LSB = 24;
  localparam int W0_STEP_LSB = 16;
  localparam int W0_OUT_LSB = 24;
  localparam int W0_EVT_LSB = 30;
  localparam int W1_DUR_LSB = 16;
  localparam int STAT_BUSY_BIT = 24;

  // Reset values
  localparam logic [OUT_W-1:0] NOUT_RST = 5'h14;

  typedef struct packed {
    logic [FORM_W-1:0] form;
    logic [STEP_W-1:0] step;
    logic [OUT_W-1:0] outn;
    logic [EVT_W-1:0] evt;
    logic [TIME_W-1:0] dly;
    logic [TIME_W-1:0] dur;
  } pos_entry_t;

  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_RUN = 2'b01,
    SC_LAST = 2'b11
  } pos_scan_t;

endpackage

// ===== inc/pos_slot_if.sv
/*
  Link between the scheduler core and one output timing slot.
  Assumes both ends share one clock and reset.
*/
`timescale 1ns/1ps
interface pos_slot_if;
  logic load;
  logic tick;
  logic [pos_pkg::NEVT-1:0] end_mask;
  logic [pos_pkg::EVT_W-1:0] evt;
  logic [pos_pkg::TIME_W-1:0] dly;
  logic [pos_pkg::TIME_W-1:0] dur;
  logic [pos_pkg::OUT_W-1:0] outn;
  logic busy;
  logic on;
  logic [pos_pkg::OUT_W-1:0] on_out;

  modport ctrl (output load, tick, end_mask, evt, dly, dur, outn, input busy, on, on_out);
  modport slot (input load, tick, end_mask, evt, dly, dur, outn, output busy, on, on_out);
endinterface

// ===== hdl/pos_slot.sv
/*
  One timing slot: delay, then drive one output for a duration.
  Assumes a one-cycle seconds tick and event-end pulses from the core.
*/
`timescale 1ns/1ps
module pos_slot
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core link
  pos_slot_if.slot bus
);

  logic busy_q;
  logic [pos_pkg::EVT_W-1:0] evt_q;
  logic [pos_pkg::TIME_W-1:0] dly_q;
  logic [pos_pkg::TIME_W-1:0] dur_q;
  logic [pos_pkg::OUT_W-1:0] out_q;
  wire [pos_pkg::NEVT:0] end_x = {bus.end_mask, 1'b0};
  wire kill = busy_q & end_x[evt_q];
  wire dly_zero = (dly_q == '0);
  wire dur_one = (dur_q == {{(pos_pkg::TIME_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      evt_q <= pos_pkg::EVT_OFF;
      dly_q <= '0;
      dur_q <= '0;
      out_q <= '0;
    end
    else if (bus.load)
    begin
      busy_q <= 1'b1;
      evt_q <= bus.evt;
      dly_q <= bus.dly;
      dur_q <= bus.dur;
      out_q <= bus.outn;
    end
    else if (kill)
    begin
      // Controlling event ended: drop at once
      busy_q <= 1'b0;
      dur_q <= '0;
    end
    else if (busy_q && bus.tick)
    begin
      if (!dly_zero)
        dly_q <= dly_q - 1'b1;
      else
      begin
        dur_q <= dur_q - 1'b1;
        if (dur_one)
          busy_q <= 1'b0;
      end
    end
  end

  assign bus.busy = busy_q;
  assign bus.on = busy_q & dly_zero & (dur_q != '0);
  assign bus.on_out = out_q;

endmodule

// ===== verification/pos_scheduler_sva.sv
/*
  Port-level checker of the output scheduler: APB timing and relay release.
  Assumes the bench binds it to the top module and drives aligned addresses.
*/
`timescale 1ns/1ps
module pos_scheduler_sva
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Relays
  input wire logic [19:0] OUT_RELAY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [2:0] evt_q;
  // Only the first access cycle counts, the ready cycle repeats the request
  wire mach_wr = PSEL && PENABLE && PWRITE && !PREADY && (PADDR == pos_pkg::A_MACH);
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      evt_q <= 3'h0;
    else if (mach_wr)
      evt_q <= PWDATA[26:24];

  reset_off_a: assert property (disable iff (1'b0) !RST_N |-> OUT_RELAY == 20'h0)
    else $error("relays driven during reset");
  ready_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  // Unaligned offsets are unmapped as well
  err_decode_a: assert property (PREADY |-> (PSLVERR == (($past(PADDR) > pos_pkg::A_STATUS) ||
                                 ($past(PADDR[1:0]) != 2'h0))))
    else $error("error flag does not match address decode");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  event_end_a: assert property (mach_wr && PWDATA[26:24] == 3'h0 |-> ##[1:4] OUT_RELAY == 20'h0)
    else $error("relays not released at event end");
  relay_cause_a: assert property ((OUT_RELAY & ~$past(OUT_RELAY)) != 20'h0 |-> evt_q != 3'h0)
    else $error("relay rose with no event active");
  cover property (mach_wr && PWDATA[26:24] == 3'h0);
endmodule

// ===== verification/pos_relay_bank.sv
/*
  Behavioural bank of relay contacts driving pumps and valves.
  Assumes one drive bit per relay, high to energise.
*/
`timescale 1ns/1ps
module pos_relay_bank
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Coil drives and contacts
  input wire logic [19:0] coil,
  output logic [19:0] contact
);
  // One-cycle pull-in lag; a real contact bounces, ignored here
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      contact <= 20'h0;
    else
      contact <= coil;
endmodule

// ===== verification/tb_top.sv
/*
  Self-checking bench of the output scheduler with a table-driven model.
  Assumes a short seconds tick of 8 cycles and an APB master in the bench.
*/
`timescale 1ns/1ps
module tb_top;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [19:0] OUT_RELAY;
  logic [19:0] contact;
  int fail_count = 0;
  int check_count = 0;
  int ef[24], es[24], eo[24], ee[24], ed[24], eu[24];
  int fv[3] = '{2, 150, 7};
  int dv[3] = '{0, 5, 40};
  int uv[4] = '{0, 5, 60, 10000};
  // Per pass: machine formula, networked, step time, output count
  int pf[3] = '{2, 150, 150};
  int pn[3] = '{0, 0, 1};
  int pt[3] = '{30, 30, 50};
  int po[3] = '{20, 20, 18};

  always #4 REF_CLK = ~REF_CLK;

  pos_scheduler #(.TICK_CYCLES(8)) u_pos_scheduler (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OUT_RELAY(OUT_RELAY));
  pos_relay_bank u_pos_relay_bank (.clk(REF_CLK), .rst_n(RST_N), .coil(OUT_RELAY),
    .contact(contact));

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (PREADY !== 1'b1);
    // One wait state; a hang is left to the watchdog
    chk("ready_wait", n, 32'h2);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Expected relay mask s cycles after the event start of kind ev in pass p
  function automatic logic [19:0] model(int s, int ev, int p);
    logic [19:0] m;
    m = 20'h0;
    for (int k = 0; k < 24; k++)
      if (ee[k] == ev && ef[k] == pf[p] && ef[k] >= 1 && ef[k] <= 999
          && (ef[k] <= 99 || pn[p] == 1) && es[k] == 1
          && eo[k] < po[p] && eo[k] <= 19
          && eu[k] != 0 && eu[k] <= 9999 && ed[k] <= pt[p]
          && ed[k] * 8 + 48 < s && (ed[k] + eu[k]) * 8 > s)
        m[eo[k]] = 1'b1;
    return m;
  endfunction

  initial
  begin
    logic [31:0] rd;
    logic er;
    logic [31:0] w0;
    logic [31:0] w1;
    int n;
    n = $urandom(32'h120A);
    repeat (20) @(posedge REF_CLK);
    chk("relay_in_reset", OUT_RELAY, 32'h0);
    RST_N <= 1'b1;
    apb(1'b0, pos_pkg::A_CTRL, 32'h0, rd, er);
    chk("ctrl_reset", rd, 32'h1400);
    for (int a = 8'h1C; a <= 8'h24; a += 8)
    begin
      apb(1'b0, a[7:0], 32'h0, rd, er);
      chk("unmapped_err", er, 32'h1);
      chk("unmapped_data", rd, 32'h0);
    end
    // Table memory has no reset, so every entry is written first
    for (int i = 0; i < 4096; i++)
    begin
      w0 = 32'h0;
      w1 = 32'h0;
      if (i < 24)
      begin
        ef[i] = fv[$urandom % 3];
        es[i] = 1 + $urandom % 2;
        eo[i] = $urandom % 22;
        ee[i] = $urandom % 4;
        ed[i] = dv[$urandom % 3];
        eu[i] = uv[$urandom % 4];
        w0 = (ee[i] << 30) | (eo[i] << 24) | (es[i] << 16) | ef[i];
        w1 = (eu[i] << 16) | ed[i];
      end
      apb(1'b1, pos_pkg::A_TBL_ADDR, i, rd, er);
      apb(1'b1, pos_pkg::A_TBL_W0, w0, rd, er);
      apb(1'b1, pos_pkg::A_TBL_W1, w1, rd, er);
    end
    apb(1'b1, pos_pkg::A_TBL_ADDR, 32'h3, rd, er);
    apb(1'b0, pos_pkg::A_TBL_W0, 32'h0, rd, er);
    chk("entry_w0", rd, (ee[3] << 30) | (eo[3] << 24) | (es[3] << 16) | ef[3]);
    apb(1'b0, pos_pkg::A_TBL_W1, 32'h0, rd, er);
    chk("entry_w1", rd, (eu[3] << 16) | ed[3]);
    for (int p = 0; p < 3; p++)
    begin
      apb(1'b1, pos_pkg::A_CTRL, pn[p] | (po[p] << 8), rd, er);
      apb(1'b1, pos_pkg::A_STEPTIME, pt[p], rd, er);
      for (int ev = 1; ev <= 3; ev++)
      begin
        apb(1'b1, pos_pkg::A_MACH, pf[p] | (1 << 16) | (1 << (23 + ev)), rd, er);
        repeat (160) @(posedge REF_CLK);
        chk("relay_early", OUT_RELAY, model(160, ev, p));
        chk("contact_early", contact, model(160, ev, p));
        repeat (440) @(posedge REF_CLK);
        chk("relay_late", OUT_RELAY, model(600, ev, p));
        apb(1'b0, pos_pkg::A_STATUS, 32'h0, rd, er);
        chk("status_relays", rd & 32'hFFFFF, model(600, ev, p));
        apb(1'b1, pos_pkg::A_MACH, pf[p] | (1 << 16), rd, er);
        repeat (4) @(posedge REF_CLK);
        chk("relay_end", OUT_RELAY, 32'h0);
        n = 0;
        do
        begin
          apb(1'b0, pos_pkg::A_STATUS, 32'h0, rd, er);
          n++;
        end
        while (rd[24] !== 1'b0 && n < 2000);
        chk("scan_done", rd[24], 32'h0);
      end
    end
    wrap_up();
  end

  initial
  begin
    // Table load and nine scans take about 86000 cycles
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    wrap_up();
  end
endmodule

bind pos_scheduler pos_scheduler_sva u_pos_scheduler_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OUT_RELAY(OUT_RELAY));
